// file: core/scr_pkg.sv
// Shared constants and types of the sensor configuration register
package scr_pkg;
    // ----------------------------------------------------------------
    // Map and field layout
    // ----------------------------------------------------------------
    localparam logic [7:0] PTR_CONFIG = 8'h01;
    localparam logic [3:0] DEV_ADDR_FIXED = 4'h9;
    localparam int ADDR_PIN_W = 3;
    localparam int CFG_W = 16;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [6:0] RESERVED_VAL = 7'h00;
    localparam logic [7:0] NO_DATA_BYTE = 8'hff;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int T_CONV_9B_MS = 25;
    localparam int CLK_KHZ = 125000;
    localparam int CONV_9B_CYCLES = T_CONV_9B_MS * CLK_KHZ;
    localparam int BASE_BITS = 9;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic one_shot_request;
        logic [1:0] resolution_select;
        logic [1:0] fault_count_select;
        logic alarm_polarity;
        logic thermostat_mode_select;
        logic shutdown_request;
    } scr_cfg_s;

    typedef enum logic [1:0] {RUN_LOAD, RUN_CONV, RUN_SLEEP} scr_run_e;
    typedef enum logic [2:0] {LNK_IDLE, LNK_RX, LNK_ACK, LNK_TX, LNK_MACK} scr_link_e;

    function automatic logic [2:0] scr_fault_depth(input logic [1:0] sel);
        logic [2:0] n;
        unique case (sel)
            2'b00: n = 3'h1;
            2'b01: n = 3'h2;
            2'b10: n = 3'h4;
            2'b11: n = 3'h6;
        endcase
        return n;
    endfunction
endpackage

// file: core/scr_sync.sv
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/100ps
`default_nettype none
module scr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// file: core/scr_conv_timer.sv
// Conversion timer whose length doubles per extra bit of resolution
`timescale 1ns/100ps
`default_nettype none
module scr_conv_timer
    import scr_pkg::*;
#(
    parameter int BASE_CYCLES = CONV_9B_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic [1:0] res_i,
    output logic busy_o,
    output logic done_o
);
    logic [31:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic done_q, done_d;

    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start_i && !busy_q) begin
            cnt_d = 32'(BASE_CYCLES) << res_i;
            busy_d = 1'b1;
        end else if (busy_q) begin
            cnt_d = cnt_q - 32'h1;
            if (cnt_q == 32'h1) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= 32'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;

    a_conv_load: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        start_i && !busy_q |=> busy_q && cnt_q == (32'(BASE_CYCLES) << $past(res_i)))
        else $error("conversion length does not follow resolution");
endmodule
`default_nettype wire

// file: core/scr_top.sv
// Sensor operating-configuration register with its two-wire slave port
`timescale 1ns/100ps
`default_nettype none
module scr_top
    import scr_pkg::*;
#(
    parameter int CONV_BASE_CYCLES = CONV_9B_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [ADDR_PIN_W-1:0] strapped_addr_pins_i,
    input wire logic [7:0] nv_config_i,
    input wire logic register_lock_flag_i,
    input wire logic permanent_lockdown_flag_i,
    input wire logic store_busy_flag_i,
    input wire logic copy_to_store_i,
    output logic store_copy_o,
    output logic [7:0] store_cfg_byte_o,
    output scr_cfg_s config_o,
    output logic [3:0] conv_bits_o,
    output logic [2:0] fault_count_o,
    output logic conv_active_o,
    output logic result_update_o
);
    // ----------------------------------------------------------------
    // Register domain
    // ----------------------------------------------------------------
    scr_cfg_s cfg_q, cfg_d;
    scr_run_e run_q, run_d;
    logic copy_q, copy_d;
    logic [7:0] copy_byte_q, copy_byte_d;
    logic [CFG_W-1:0] pub_q, pub_d;
    logic req_q, req_d;
    logic wr_tgl_p_q, wr_tgl_s, ack_s;
    logic conv_start, conv_done, upd_d, upd_q;
    logic locked, wr_evt;
    logic [CFG_W-1:0] rd_word;
    logic [7:0] cfg_v;
    // Link-side flops: both toggles pass u_sys_sync, only the byte is read here as a stable word
    logic wr_tgl_q, ack_q;
    logic [7:0] wr_byte_q;

    scr_sync #(.WIDTH(2)) u_sys_sync (
        .clk_i(sys_clk_i),
        .rst_i(sys_rst_i),
        .d_i({wr_tgl_q, ack_q}),
        .q_o({wr_tgl_s, ack_s})
    );

    scr_conv_timer #(.BASE_CYCLES(CONV_BASE_CYCLES)) u_timer (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(conv_start),
        // Next value, so the power-up conversion already runs at the stored resolution
        .res_i(cfg_d.resolution_select),
        .busy_o(conv_active_o),
        .done_o(conv_done)
    );

    assign cfg_v = cfg_q;
    assign locked = register_lock_flag_i | permanent_lockdown_flag_i;
    assign wr_evt = wr_tgl_s ^ wr_tgl_p_q;
    // One-shot hidden, reserved zero, busy in bit 0
    assign rd_word = {1'b0, cfg_v[6:0], RESERVED_VAL, store_busy_flag_i};

    always_comb begin
        cfg_d = cfg_q;
        run_d = run_q;
        conv_start = 1'b0;
        upd_d = 1'b0;
        unique case (run_q)
            RUN_LOAD: begin
                // Always measure once so the result is valid after reset
                cfg_d = scr_cfg_s'(nv_config_i);
                run_d = RUN_CONV;
                conv_start = 1'b1;
            end
            RUN_CONV: begin
                if (conv_done) begin
                    upd_d = 1'b1;
                    if (!cfg_q.shutdown_request) begin
                        conv_start = 1'b1;
                    end else begin
                        run_d = RUN_SLEEP;
                        cfg_d.one_shot_request = 1'b0;
                    end
                end
            end
            RUN_SLEEP: begin
                if (!cfg_q.shutdown_request || cfg_q.one_shot_request) begin
                    run_d = RUN_CONV;
                    conv_start = 1'b1;
                end
            end
        endcase
        if (wr_evt && !locked && run_q != RUN_LOAD) begin
            cfg_d = scr_cfg_s'(wr_byte_q);
            cfg_d.one_shot_request = wr_byte_q[7] && wr_byte_q[0] && run_q == RUN_SLEEP;
        end
    end

    always_comb begin
        copy_d = 1'b0;
        copy_byte_d = copy_byte_q;
        if (copy_to_store_i && !store_busy_flag_i) begin
            copy_d = 1'b1;
            copy_byte_d = {1'b0, cfg_v[6:0]};
        end
    end

    // Republish the read word only when the link has taken the last one
    always_comb begin
        pub_d = pub_q;
        req_d = req_q;
        if (req_q == ack_s && pub_q != rd_word) begin
            pub_d = rd_word;
            req_d = ~req_q;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_q <= scr_cfg_s'(CFG_RST);
            run_q <= RUN_LOAD;
            copy_q <= 1'b0;
            copy_byte_q <= CFG_RST;
            pub_q <= '0;
            req_q <= 1'b0;
            wr_tgl_p_q <= 1'b0;
            upd_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            run_q <= run_d;
            copy_q <= copy_d;
            copy_byte_q <= copy_byte_d;
            pub_q <= pub_d;
            req_q <= req_d;
            wr_tgl_p_q <= wr_tgl_s;
            upd_q <= upd_d;
        end
    end

    assign config_o = cfg_q;
    assign conv_bits_o = 4'(BASE_BITS) + {2'b00, cfg_q.resolution_select};
    assign fault_count_o = scr_fault_depth(cfg_q.fault_count_select);
    assign store_copy_o = copy_q;
    assign store_cfg_byte_o = copy_byte_q;
    assign result_update_o = upd_q;

    // ----------------------------------------------------------------
    // Link domain
    // ----------------------------------------------------------------
    logic [1:0] lrst_q;
    logic lrst;
    logic [5:0] pin_s;
    logic scl, sda, scl_p_q, sda_p_q, scl_rise, scl_fall, bus_start, bus_stop;
    logic [ADDR_PIN_W-1:0] addr;
    logic req_s;
    scr_link_e st_q, st_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wr_byte_d, txb;
    logic [2:0] cnt_q, cnt_d;
    logic [1:0] idx_q, idx_d;
    logic rd_q, rd_d, full_q, full_d, drv_q, drv_d, hi_q, hi_d, mack_q, mack_d;
    logic wr_tgl_d, ack_d;
    logic [CFG_W-1:0] snap_q, snap_d;

    // Reset is asserted at once and released on the link clock
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lrst_q <= 2'b11;
        end else begin
            lrst_q <= {lrst_q[0], 1'b0};
        end
    end
    assign lrst = lrst_q[1];

    scr_sync #(.WIDTH(6)) u_link_sync (
        .clk_i(link_clk_i),
        .rst_i(lrst),
        .d_i({req_q, scl_i, sda_i, strapped_addr_pins_i}),
        .q_o(pin_s)
    );

    assign {req_s, scl, sda, addr} = pin_s;
    assign scl_rise = scl & ~scl_p_q;
    assign scl_fall = ~scl & scl_p_q;
    assign bus_start = scl & scl_p_q & ~sda & sda_p_q;
    assign bus_stop = scl & scl_p_q & sda & ~sda_p_q;
    assign txb = (ptr_q != PTR_CONFIG) ? NO_DATA_BYTE : (hi_q ? snap_q[15:8] : snap_q[7:0]);

    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        rd_d = rd_q;
        full_d = full_q;
        drv_d = drv_q;
        hi_d = hi_q;
        mack_d = mack_q;
        wr_tgl_d = wr_tgl_q;
        wr_byte_d = wr_byte_q;
        snap_d = snap_q;
        ack_d = ack_q;
        if (req_s != ack_q) begin
            snap_d = pub_q;
            ack_d = req_s;
        end
        if (bus_start) begin
            st_d = LNK_RX;
            cnt_d = 3'h0;
            idx_d = 2'h0;
            full_d = 1'b0;
            drv_d = 1'b0;
        end else if (bus_stop) begin
            st_d = LNK_IDLE;
            drv_d = 1'b0;
        end else begin
            unique case (st_q)
                LNK_IDLE: begin
                end
                LNK_RX: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda};
                        cnt_d = cnt_q + 3'h1;
                        full_d = (cnt_q == 3'h7);
                    end else if (scl_fall && full_q) begin
                        full_d = 1'b0;
                        cnt_d = 3'h0;
                        idx_d = (idx_q == 2'h3) ? idx_q : idx_q + 2'h1;
                        st_d = LNK_ACK;
                        drv_d = 1'b1;
                        unique case (idx_q)
                            2'h0: begin
                                if (sh_q[7:1] == {DEV_ADDR_FIXED, addr}) begin
                                    rd_d = sh_q[0];
                                    hi_d = 1'b1;
                                end else begin
                                    st_d = LNK_IDLE;
                                    drv_d = 1'b0;
                                end
                            end
                            2'h1: ptr_d = sh_q;
                            default: begin
                                if (ptr_q != PTR_CONFIG) begin
                                    st_d = LNK_IDLE;
                                    drv_d = 1'b0;
                                end else if (idx_q == 2'h2) begin
                                    wr_byte_d = sh_q;
                                    wr_tgl_d = ~wr_tgl_q;
                                end
                            end
                        endcase
                    end
                end
                LNK_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 3'h0;
                        if (rd_q) begin
                            st_d = LNK_TX;
                            sh_d = txb;
                            drv_d = ~txb[7];
                            hi_d = ~hi_q;
                        end else begin
                            st_d = LNK_RX;
                            drv_d = 1'b0;
                        end
                    end
                end
                LNK_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == 3'h7) begin
                            st_d = LNK_MACK;
                            drv_d = 1'b0;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b1};
                            drv_d = ~sh_q[6];
                            cnt_d = cnt_q + 3'h1;
                        end
                    end
                end
                LNK_MACK: begin
                    if (scl_rise) begin
                        mack_d = ~sda;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            st_d = LNK_TX;
                            sh_d = txb;
                            drv_d = ~txb[7];
                            hi_d = ~hi_q;
                            cnt_d = 3'h0;
                        end else begin
                            st_d = LNK_IDLE;
                        end
                    end
                end
                default: st_d = LNK_IDLE;
            endcase
        end
    end

    always_ff @(posedge link_clk_i or posedge lrst) begin
        if (lrst) begin
            st_q <= LNK_IDLE;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            cnt_q <= 3'h0;
            idx_q <= 2'h0;
            rd_q <= 1'b0;
            full_q <= 1'b0;
            drv_q <= 1'b0;
            hi_q <= 1'b1;
            mack_q <= 1'b0;
            wr_tgl_q <= 1'b0;
            wr_byte_q <= 8'h00;
            snap_q <= '0;
            ack_q <= 1'b0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            rd_q <= rd_d;
            full_q <= full_d;
            drv_q <= drv_d;
            hi_q <= hi_d;
            mack_q <= mack_d;
            wr_tgl_q <= wr_tgl_d;
            wr_byte_q <= wr_byte_d;
            snap_q <= snap_d;
            ack_q <= ack_d;
            scl_p_q <= scl;
            sda_p_q <= sda;
        end
    end

    // Open drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~drv_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_power_load: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        run_q == RUN_LOAD |=> cfg_v == $past(nv_config_i) && run_q == RUN_CONV)
        else $error("configuration not loaded from store");
    a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        pub_q[7:1] == RESERVED_VAL && pub_q[15] == 1'b0)
        else $error("reserved or one-shot bit reads nonzero");
    a_lock_ignore: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        wr_evt && locked |=> cfg_v[6:0] == $past(cfg_v[6:0]))
        else $error("locked write changed configuration");
    a_write_upper: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        wr_evt && !locked && run_q != RUN_LOAD |=> cfg_v[6:0] == $past(wr_byte_q[6:0]))
        else $error("data byte not placed in upper byte");
    a_os_ignored: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        wr_evt && !locked && run_q == RUN_CONV |=> !cfg_q.one_shot_request)
        else $error("one-shot accepted outside shutdown");
    a_oneshot_done: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        run_q == RUN_CONV && conv_done && cfg_q.shutdown_request
        |=> !cfg_q.one_shot_request && run_q == RUN_SLEEP ##0 result_update_o)
        else $error("one-shot not completed and cleared");
    a_sleep_idle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        run_q == RUN_SLEEP && cfg_q.shutdown_request && !cfg_q.one_shot_request
        ##1 run_q == RUN_SLEEP |-> !conv_active_o)
        else $error("conversion running in shutdown");
    a_finish_conv: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        conv_active_o && !conv_done && cfg_q.shutdown_request |=> conv_active_o || conv_done)
        else $error("conversion cut short by shutdown");
    a_copy_store: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        copy_to_store_i && !store_busy_flag_i
        |=> store_copy_o && store_cfg_byte_o == {1'b0, $past(cfg_v[6:0])})
        else $error("copy to store missing or wrong");
    a_copy_busy: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        copy_to_store_i && store_busy_flag_i |=> !store_copy_o)
        else $error("copy issued while store busy");
    a_fault_six: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        cfg_q.fault_count_select == 2'b11 |-> fault_count_o == 3'h6)
        else $error("fault depth decode wrong");
    a_first_byte: assert property (@(posedge link_clk_i) disable iff (lrst)
        $changed(wr_tgl_q) |-> $past(idx_q) == 2'h2)
        else $error("data byte after the first was taken");
    a_stop_drop: assert property (@(posedge link_clk_i) disable iff (lrst)
        bus_stop |=> $stable(wr_tgl_q) && st_q == LNK_IDLE)
        else $error("stop did not abandon the byte");
    a_data_ack: assert property (@(posedge link_clk_i) disable iff (lrst)
        st_q == LNK_RX && scl_fall && full_q && idx_q == 2'h2 && ptr_q == PTR_CONFIG
        && !bus_start && !bus_stop |=> drv_q)
        else $error("data byte not acknowledged");

    c_oneshot: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        run_q == RUN_SLEEP && cfg_q.one_shot_request);
    c_cfg_write: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        wr_evt && !locked);
    c_lock_write: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        wr_evt && locked);
    c_read_word: cover property (@(posedge link_clk_i) disable iff (lrst)
        st_q == LNK_MACK && scl_fall && mack_q);
endmodule
`default_nettype wire

// file: verif/scr_bus_master.sv
// Behavioural two-wire bus master facing the sensor port
`timescale 1ns/100ps
`default_nettype none
module scr_bus_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // ----------------------------------------------------------------
    // Line phases
    // ----------------------------------------------------------------
    // A quarter bit is 30 system cycles: each SCL phase spans 10 link clocks
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic qtr();
        repeat (30) @(negedge clk_i);
    endtask
    task automatic start();
        sda_low_o = 1'b0;
        qtr();
        scl_o = 1'b1;
        qtr();
        sda_low_o = 1'b1;
        qtr();
        scl_o = 1'b0;
        qtr();
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        qtr();
        scl_o = 1'b1;
        qtr();
        sda_low_o = 1'b0;
        qtr();
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_low_o = ~b;
        qtr();
        scl_o = 1'b1;
        qtr();
        r = sda_i;
        qtr();
        scl_o = 1'b0;
        qtr();
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~mack, r);
    endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the sensor configuration register
`timescale 1ns/100ps
`default_nettype none
module tb
    import scr_pkg::*;
;
    localparam int CB = 20;
    logic clk = 0, lclk = 0, rst = 1, scl, mlow, lk = 0, ld = 0, busy = 1, cp = 0;
    logic oe_n, sdo, sc, up, ack, ca;
    logic [7:0] nv = 8'h5b, sb;
    logic [3:0] cb;
    logic [2:0] fc;
    logic [15:0] w;
    scr_cfg_s cfg;
    int fail_count = 0, samples_checked = 0, ups = 0, n, u, p;
    logic [7:0] wv[5] = '{8'h2a, 8'h54, 8'h7f, 8'h00, 8'h80};
    logic [7:0] ev[5] = '{8'h2a, 8'h54, 8'h7f, 8'h00, 8'h00};
    logic [2:0] fd[4] = '{3'h1, 3'h2, 3'h4, 3'h6};
    // Open-drain wire with pull-up
    wire logic sda = ~(mlow | (~oe_n & ~sdo));
    initial forever #4 clk = ~clk;
    initial begin
        #7;
        forever #24 lclk = ~lclk;
    end
    always @(posedge clk) if (up === 1'b1) ups <= ups + 1;
    scr_top #(.CONV_BASE_CYCLES(CB)) DUT (.sys_clk_i(clk), .sys_rst_i(rst),
        .link_clk_i(lclk), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_n_o(oe_n),
        .strapped_addr_pins_i(3'h5), .nv_config_i(nv), .register_lock_flag_i(lk),
        .permanent_lockdown_flag_i(ld), .store_busy_flag_i(busy), .copy_to_store_i(cp),
        .store_copy_o(sc), .store_cfg_byte_o(sb), .config_o(cfg), .conv_bits_o(cb),
        .fault_count_o(fc), .conv_active_o(ca), .result_update_o(up));
    scr_bus_master m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(mlow));
    // ----------------------------------------------------------------
    // Checks and bus cycles
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr_cfg(input logic [7:0] d, input logic extra, output logic a);
        logic a1, a2, a3, a4;
        m.start();
        m.wr({DEV_ADDR_FIXED, 3'h5, 1'b0}, a1);
        m.wr(PTR_CONFIG, a2);
        m.wr(d, a3);
        a4 = 1'b1;
        if (extra) m.wr(8'h7f, a4);
        m.stop();
        a = a1 & a2 & a3 & a4;
    endtask
    task automatic rd_cfg(output logic [15:0] r);
        logic a;
        m.start();
        m.wr({DEV_ADDR_FIXED, 3'h5, 1'b0}, a);
        m.wr(PTR_CONFIG, a);
        m.start();
        m.wr({DEV_ADDR_FIXED, 3'h5, 1'b1}, a);
        m.rd(1'b1, r[15:8]);
        m.rd(1'b0, r[7:0]);
        m.stop();
    endtask
    // Counts cycles up to the next end of conversion, bounded
    task automatic wait_up(output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
            if (c > 4000) begin
                fail_count++;
                $display("ERROR %0t: no conversion end", $time);
                test_done();
            end
        end while (up !== 1'b1);
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clk);
        rst = 0;
        repeat (2) @(negedge clk);
        chk({8'h0, cfg}, {8'h0, nv});
        chk({12'h0, cb}, 16'hb);
        chk({13'h0, fc}, 16'h6);
        repeat (60) @(negedge clk);
        rd_cfg(w);
        chk(w, 16'h5b01);
        busy = 0;
        u = ups;
        wr_cfg(8'h81, 1'b0, ack);
        repeat (100) @(negedge clk);
        chk({8'h0, cfg}, 16'h0001);
        chk(16'(ups - u), 16'h1);
        chk({15'h0, ca}, 16'h0);
        rd_cfg(w);
        chk(w, 16'h0100);
        $display("reset, read and one-shot done");
        foreach (wv[i]) begin
            wr_cfg(wv[i], 1'b0, ack);
            chk({8'h0, cfg}, {8'h0, ev[i]});
            chk({12'h0, cb}, 16'(9 + ev[i][6:5]));
            chk({13'h0, fc}, {13'h0, fd[ev[i][4:3]]});
            if (!ev[i][0]) begin
                p = CB << ev[i][6:5];
                wait_up(n);
                chk({15'h0, ca}, 16'h1);
                wait_up(n);
                chk(16'(n >= p && n <= p + 3), 16'h1);
            end
        end
        $display("field decode done");
        wr_cfg(8'h21, 1'b1, ack);
        chk({8'h0, cfg}, 16'h21);
        m.start();
        m.wr({DEV_ADDR_FIXED, 3'h5, 1'b0}, ack);
        m.wr(PTR_CONFIG, ack);
        repeat (4) m.bit_io(1'b1, ack);
        m.stop();
        chk({8'h0, cfg}, 16'h21);
        for (int k = 0; k < 2; k++) begin
            {ld, lk} = k ? 2'b10 : 2'b01;
            wr_cfg(8'h33, 1'b0, ack);
            chk({15'h0, ack}, 16'h1);
            chk({8'h0, cfg}, 16'h21);
        end
        {ld, lk} = 2'b00;
        m.start();
        m.wr({DEV_ADDR_FIXED, 3'h2, 1'b0}, ack);
        m.stop();
        chk({15'h0, ack}, 16'h0);
        $display("refused writes done");
        cp = 1;
        @(negedge clk);
        cp = 0;
        chk({7'h0, sc, sb}, 16'h0121);
        busy = 1;
        cp = 1;
        @(negedge clk);
        cp = 0;
        chk({15'h0, sc}, 16'h0);
        $display("store copy done");
        test_done();
    end
endmodule
`default_nettype wire
